// *** design/aivs_pkg.sv ***
// Constants and encodings for the analog input value substitution block
// Notes on behaviour
// [RULE1] After reset or parameter commit, report 7FFF per channel until its first new sample.
// [RULE2] Without load supply every channel reports 7FFF, in run or stop alike.
// [RULE3] Supply present and valid parameters give live values, independent of run or stop.
// [RULE4] Nominal, overshoot and underrange samples pass unchanged in both formats.
// [RULE5] Overflow gives 7FFF signed, or overshoot end plus one with overflow bit in legacy.
// [RULE6] Underflow gives 8000 signed, or underrange end minus one with overflow bit in legacy.
// [RULE7] Absent or invalid parameters give 7FFF in both formats.
// [RULE8] A deactivated channel always reports 7FFF whatever its terminals see.
// [RULE9] The configuring master deactivates every unused channel.
// [RULE10] Channel values are 16-bit two's-complement numbers.
// [RULE11] Bit 15 carries the sign, zero positive and one negative.
// [RULE12] Priority: deactivated, no supply, bad parameters, no sample, over/underflow, measured.
package aivs_pkg;
   localparam int NCH = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = WORD_W + 1;

   // Substitute codes
   localparam logic [15:0] CODE_SUBST = 16'h7fff;
   localparam logic [15:0] CODE_UNDER = 16'h8000;
   localparam logic [15:0] OVS_END = 16'h7eff;
   localparam logic [15:0] UNR_END = 16'h8100;
   localparam logic [15:0] OVF_MASK = 16'h0001;
   localparam logic [15:0] LEG_OVER = OVS_END + 16'h0001;
   localparam logic [15:0] LEG_UNDER = UNR_END - 16'h0001;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] DATA0_OFF = 8'h08;
   localparam logic [7:0] DATA1_OFF = 8'h0c;
   localparam logic [7:0] FIFO_OFF = 8'h10;

   // Control fields
   localparam int CTRL_PARAM_BIT = 0;
   localparam int CTRL_LEGACY_BIT = 1;
   localparam int CTRL_DEACT_LSB = 2;
   localparam logic CTRL_PARAM_RST = 1'b0;
   localparam logic CTRL_LEGACY_RST = 1'b0;
   localparam logic [1:0] CTRL_DEACT_RST = 2'h0;

   // Status fields
   localparam int STAT_SUPPLY_BIT = 0;
   localparam int STAT_SEEN_LSB = 1;
   localparam int STAT_FIFO_BIT = 3;

   // Fifo read word fields
   localparam int FIFO_CH_BIT = 16;
   localparam int FIFO_VALID_BIT = 31;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {WR_IDLE, WR_RESP} aivs_wr_st_t;
   typedef enum logic {RD_IDLE, RD_RESP} aivs_rd_st_t;
endpackage

// *** design/aivs_top.sv ***
// Sample fifo and the value substitution top with its AXI4-Lite register slave
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

module aivs_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_push_valid,
   output logic o_push_ready,
   input wire logic [WIDTH-1:0] i_push_data,
   output logic o_pop_valid,
   input wire logic i_pop_ready,
   output logic [WIDTH-1:0] o_pop_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign push = i_push_valid && o_push_ready;
   assign pop = o_pop_valid && i_pop_ready;
   assign o_pop_data = mem_q[rd_q];

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         cnt_q <= '0;
         o_push_ready <= 1'b1;
         o_pop_valid <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         o_push_ready <= (cnt_d != FULL_CNT);
         o_pop_valid <= (cnt_d != '0);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_push_data;
      end
   end
endmodule

module aivs_top
   import aivs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_supply_ok,
   input wire logic i_smp_valid,
   input wire logic i_smp_ch,
   input wire logic [15:0] i_smp_code,
   input wire logic i_smp_ovf,
   input wire logic i_smp_unf,
   output logic o_smp_ready,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [ADDR_W-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp
);
   aivs_wr_st_t wr_st_q;
   aivs_rd_st_t rd_st_q;
   logic aw_got_q;
   logic w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic wstrb0_q;
   logic param_ok_q;
   logic legacy_q;
   logic [NCH-1:0] deact_q;
   logic [NCH-1:0] seen_q;
   logic [NCH-1:0] seen_d;
   logic [15:0] code_q [NCH];
   logic [NCH-1:0] ovf_q;
   logic [NCH-1:0] unf_q;
   logic wr_fire;
   logic commit;
   logic smp_fire;
   logic [15:0] push_word;
   logic ar_fire;
   logic fifo_pop;
   logic fifo_valid;
   logic [FIFO_W-1:0] fifo_data;
   logic [DATA_W-1:0] rd_mux;
   logic [15:0] ch_word [NCH];

   // Substituted input word; earlier tests win
   function automatic logic [15:0] subst(input logic deact, input logic supply, input logic param,
                                         input logic seen, input logic legacy, input logic ovf,
                                         input logic unf, input logic [15:0] code);
      logic [15:0] w;
      w = code;                                           // see [RULE3] see [RULE4] see [RULE10]
      if (deact) begin
         w = CODE_SUBST;                                  // see [RULE8] see [RULE12]
      end else if (!supply) begin
         w = CODE_SUBST;                                  // see [RULE2]
      end else if (!param) begin
         w = CODE_SUBST;                                  // see [RULE7]
      end else if (!seen) begin
         w = CODE_SUBST;                                  // see [RULE1]
      end else if (ovf) begin
         w = legacy ? (LEG_OVER | OVF_MASK) : CODE_SUBST; // see [RULE5]
      end else if (unf) begin
         w = legacy ? (LEG_UNDER | OVF_MASK) : CODE_UNDER; // see [RULE6]
      end
      return w;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == CTRL_OFF) || (a == STATUS_OFF) || (a == DATA0_OFF) || (a == DATA1_OFF) ||
             (a == FIFO_OFF);
   endfunction

   // Write channel
   assign wr_fire = (wr_st_q == WR_IDLE) && aw_got_q && w_got_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         wr_st_q <= WR_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
      end else begin
         case (wr_st_q)
            WR_IDLE: begin
               if (i_awvalid && o_awready) begin
                  awaddr_q <= i_awaddr;
                  aw_got_q <= 1'b1;
                  o_awready <= 1'b0;
               end
               if (i_wvalid && o_wready) begin
                  wdata_q <= i_wdata;
                  wstrb0_q <= i_wstrb[0];
                  w_got_q <= 1'b1;
                  o_wready <= 1'b0;
               end
               if (wr_fire) begin
                  aw_got_q <= 1'b0;
                  w_got_q <= 1'b0;
                  o_bvalid <= 1'b1;
                  o_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
                  wr_st_q <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (i_bready) begin
                  o_bvalid <= 1'b0;
                  o_awready <= 1'b1;
                  o_wready <= 1'b1;
                  wr_st_q <= WR_IDLE;
               end
            end
            default: wr_st_q <= WR_IDLE;
         endcase
      end
   end

   // Control register; writing the parameter flag as one is a parameter commit
   assign commit = wr_fire && (awaddr_q == CTRL_OFF) && wstrb0_q && wdata_q[CTRL_PARAM_BIT];

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         param_ok_q <= CTRL_PARAM_RST;
         legacy_q <= CTRL_LEGACY_RST;
         deact_q <= CTRL_DEACT_RST;
      end else if (wr_fire && (awaddr_q == CTRL_OFF) && wstrb0_q) begin
         param_ok_q <= wdata_q[CTRL_PARAM_BIT];
         legacy_q <= wdata_q[CTRL_LEGACY_BIT];
         deact_q <= wdata_q[CTRL_DEACT_LSB +: NCH];
      end
   end

   // Sample intake, stalled by the fifo
   assign smp_fire = i_smp_valid && o_smp_ready;
   assign push_word = subst(deact_q[i_smp_ch], i_supply_ok, param_ok_q, 1'b1, legacy_q,
                            i_smp_ovf, i_smp_unf, i_smp_code);

   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         logic hit;
         assign hit = smp_fire && (i_smp_ch == 1'(c));
         // A sample in the commit cycle still counts as the first conversion
         assign seen_d[c] = hit || (seen_q[c] && !commit); // see [RULE1]

         always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
               seen_q[c] <= 1'b0;
               code_q[c] <= '0;
               ovf_q[c] <= 1'b0;
               unf_q[c] <= 1'b0;
            end else begin
               seen_q[c] <= seen_d[c];
               if (hit) begin
                  code_q[c] <= i_smp_code;
                  ovf_q[c] <= i_smp_ovf;
                  unf_q[c] <= i_smp_unf;
               end
            end
         end

         assign ch_word[c] = subst(deact_q[c], i_supply_ok, param_ok_q, seen_q[c], legacy_q,
                                   ovf_q[c], unf_q[c], code_q[c]);
      end
   endgenerate

   aivs_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) aivs_fifo_i (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_push_valid(i_smp_valid),
      .o_push_ready(o_smp_ready),
      .i_push_data({i_smp_ch, push_word}),
      .o_pop_valid(fifo_valid),
      .i_pop_ready(fifo_pop),
      .o_pop_data(fifo_data)
   );

   // Read channel
   assign ar_fire = (rd_st_q == RD_IDLE) && i_arvalid && o_arready;
   assign fifo_pop = ar_fire && (i_araddr == FIFO_OFF) && fifo_valid;

   always_comb begin
      rd_mux = '0;
      if (i_araddr == CTRL_OFF) begin
         rd_mux[CTRL_PARAM_BIT] = param_ok_q;
         rd_mux[CTRL_LEGACY_BIT] = legacy_q;
         rd_mux[CTRL_DEACT_LSB +: NCH] = deact_q;
      end else if (i_araddr == STATUS_OFF) begin
         rd_mux[STAT_SUPPLY_BIT] = i_supply_ok;
         rd_mux[STAT_SEEN_LSB +: NCH] = seen_q;
         rd_mux[STAT_FIFO_BIT] = fifo_valid;
      end else if (i_araddr == DATA0_OFF) begin
         rd_mux[WORD_W-1:0] = ch_word[0]; // see [RULE11]
      end else if (i_araddr == DATA1_OFF) begin
         rd_mux[WORD_W-1:0] = ch_word[1]; // see [RULE11]
      end else if (i_araddr == FIFO_OFF) begin
         if (fifo_valid) begin
            rd_mux[FIFO_W-1:0] = fifo_data;
            rd_mux[FIFO_VALID_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         rd_st_q <= RD_IDLE;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= RESP_OKAY;
      end else begin
         case (rd_st_q)
            RD_IDLE: begin
               if (ar_fire) begin
                  o_rdata <= rd_mux;
                  o_rresp <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
                  o_rvalid <= 1'b1;
                  o_arready <= 1'b0;
                  rd_st_q <= RD_RESP;
               end
            end
            RD_RESP: begin
               if (i_rready) begin
                  o_rvalid <= 1'b0;
                  o_arready <= 1'b1;
                  rd_st_q <= RD_IDLE;
               end
            end
            default: rd_st_q <= RD_IDLE;
         endcase
      end
   end

   // Checks
   logic live;
   assign live = !deact_q[i_smp_ch] && i_supply_ok && param_ok_q;

   AST_DEACT: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE8]
      smp_fire && deact_q[i_smp_ch] |-> push_word == CODE_SUBST)
      else $error("deactivated channel did not give 7fff");
   AST_NO_SUPPLY: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE2]
      ar_fire && (i_araddr == DATA0_OFF) && !i_supply_ok |=> o_rvalid && o_rdata == 32'h0000_7fff)
      else $error("missing supply did not give 7fff");
   AST_NO_PARAM: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE7]
      ar_fire && (i_araddr == DATA1_OFF) && !param_ok_q |=> o_rdata[15:0] == 16'h7fff)
      else $error("absent parameters did not give 7fff");
   AST_FIRST: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE1]
      commit && !(smp_fire && !i_smp_ch) |=> !seen_q[0] && ch_word[0] == CODE_SUBST)
      else $error("commit did not restore 7fff before first sample");
   AST_LIVE: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE3] see [RULE4]
      smp_fire && live && !i_smp_ovf && !i_smp_unf |-> push_word == i_smp_code)
      else $error("measured value altered");
   AST_OVER: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE5]
      smp_fire && live && i_smp_ovf |-> push_word == (legacy_q ? 16'h7f01 : 16'h7fff))
      else $error("overflow code wrong");
   AST_UNDER: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE6]
      smp_fire && live && !i_smp_ovf && i_smp_unf |-> push_word == (legacy_q ? 16'h80ff : 16'h8000))
      else $error("underflow code wrong");
   AST_SIGN: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE10] see [RULE11]
      smp_fire && live && !i_smp_ovf && !i_smp_unf |-> push_word[15] == i_smp_code[15])
      else $error("sign bit lost");
   AST_PRIO: assert property (@(posedge i_sys_clk) disable iff (i_reset) // see [RULE12]
      smp_fire && !i_supply_ok && (i_smp_ovf || i_smp_unf) |-> push_word == CODE_SUBST)
      else $error("substitution priority wrong");
   AST_RHOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");

   COV_LIVE: cover property (@(posedge i_sys_clk) disable iff (i_reset) smp_fire && live);
   COV_FULL: cover property (@(posedge i_sys_clk) disable iff (i_reset) i_smp_valid && !o_smp_ready);
   COV_COMMIT: cover property (@(posedge i_sys_clk) disable iff (i_reset) commit ##[1:50] smp_fire);
endmodule

// *** tb/aivs_master_model.sv ***
// Bus master model of the remote CPU that reads the channel words over AXI4-Lite
`timescale 1ns/1ps

module aivs_master_model
   import aivs_pkg::*;
(
   input wire logic i_sys_clk,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [ADDR_W-1:0] o_awaddr,
   output logic o_wvalid,
   input wire logic i_wready,
   output logic [DATA_W-1:0] o_wdata,
   output logic [3:0] o_wstrb,
   input wire logic i_bvalid,
   output logic o_bready,
   output logic o_arvalid,
   input wire logic i_arready,
   output logic [ADDR_W-1:0] o_araddr,
   input wire logic i_rvalid,
   output logic o_rready
);
   initial {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;

   // Released addresses and write data show the inverse so stale values never look valid
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output bit ok);
      o_awvalid <= 1'b1;
      o_awaddr <= a;
      o_wvalid <= 1'b1;
      o_wdata <= d;
      o_wstrb <= 4'hf;
      o_bready <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge i_sys_clk);
         if (o_awvalid && i_awready) begin
            o_awvalid <= 1'b0;
            o_awaddr <= ~a;
         end
         if (o_wvalid && i_wready) begin
            o_wvalid <= 1'b0;
            o_wdata <= ~d;
         end
         if (i_bvalid === 1'b1) begin
            o_bready <= 1'b0;
            ok = 1'b1;
         end
      end
      @(posedge i_sys_clk);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output bit ok);
      o_arvalid <= 1'b1;
      o_araddr <= a;
      o_rready <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge i_sys_clk);
         if (o_arvalid && i_arready) begin
            o_arvalid <= 1'b0;
            o_araddr <= ~a;
         end
         if (i_rvalid === 1'b1) begin
            o_rready <= 1'b0;
            ok = 1'b1;
         end
      end
      @(posedge i_sys_clk);
   endtask
endmodule

// *** tb/analog_input_value_substitution_tb.sv ***
// Self-checking bench for the value substitution top and its sample fifo
`timescale 1ns/1ps

module analog_input_value_substitution_tb
   import aivs_pkg::*;
();
   logic sys_clk = 1'b0, reset = 1'b1, supply = 1'b1;
   logic smp_valid = 1'b0, smp_ch = 1'b0, smp_ovf = 1'b0, smp_unf = 1'b0;
   logic [15:0] smp_code = 16'h0, c;
   logic smp_ready, awready, wready, bvalid, arready, rvalid, awvalid, wvalid, bready, arvalid, rready;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, wdata;
   logic [7:0] awaddr, araddr;
   logic [3:0] wstrb;
   logic par = 1'b0, leg = 1'b0;
   logic [1:0] deact = 2'h0, seen = 2'h0, lovf, lunf;
   logic [15:0] lcode [2];
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   logic [31:0] fq [$];
   int num_errors = 0, check_count = 0;
   bit ok;

   always #25 sys_clk = ~sys_clk;

   aivs_top aivs_top_i (.i_sys_clk(sys_clk), .i_reset(reset), .i_supply_ok(supply), .i_smp_valid(smp_valid),
      .i_smp_ch(smp_ch), .i_smp_code(smp_code), .i_smp_ovf(smp_ovf), .i_smp_unf(smp_unf), .o_smp_ready(smp_ready),
      .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
      .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
      .o_rdata(rdata), .o_rresp(rresp));

   aivs_master_model aivs_master_model_i (.i_sys_clk(sys_clk), .o_awvalid(awvalid), .i_awready(awready),
      .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata), .o_wstrb(wstrb),
      .i_bvalid(bvalid), .o_bready(bready), .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr),
      .i_rvalid(rvalid), .o_rready(rready));

   function automatic logic [15:0] subst(input logic ch, input logic sn);
      if (deact[ch] || !supply || !par || !sn) return CODE_SUBST;
      if (lovf[ch]) return leg ? (LEG_OVER | OVF_MASK) : CODE_SUBST;
      if (lunf[ch]) return leg ? (LEG_UNDER | OVF_MASK) : CODE_UNDER;
      return lcode[ch];
   endfunction

   task automatic chk(input string nm, input logic [33:0] seen_v, input logic [33:0] exp_v);
      check_count++;
      if (seen_v !== exp_v) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bus_ok();
      if (!ok) begin
         chk("bus timeout", 34'h0, 34'h1);
         tally_and_finish();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      aivs_master_model_i.rd(a, ok);
      bus_ok();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      bq.push_back(e);
      aivs_master_model_i.wr(a, d, ok);
      bus_ok();
      if (a == CTRL_OFF) begin
         par = d[CTRL_PARAM_BIT];
         leg = d[CTRL_LEGACY_BIT];
         deact = d[CTRL_DEACT_LSB +: 2];
         if (d[CTRL_PARAM_BIT]) seen = 2'h0;
      end
   endtask

   task automatic rd_word(input logic ch);
      rd(ch ? DATA1_OFF : DATA0_OFF, {RESP_OKAY, 16'h0, subst(ch, seen[ch])});
   endtask

   task automatic rd_stat();
      rd(STATUS_OFF, {RESP_OKAY, 28'h0, fq.size() != 0, seen, supply});
   endtask

   task automatic rd_fifo();
      rd(FIFO_OFF, {RESP_OKAY, fq.size() ? fq.pop_front() : 32'h0});
   endtask

   task automatic smp(input logic ch, input logic [15:0] cv, input logic ov, input logic un);
      int n;
      smp_valid <= 1'b1;
      smp_ch <= ch;
      smp_code <= cv;
      smp_ovf <= ov;
      smp_unf <= un;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (smp_ready !== 1'b1 && n < 64);
      if (smp_ready !== 1'b1) begin
         chk("sample timeout", 34'h0, 34'h1);
         tally_and_finish();
      end
      smp_valid <= 1'b0;
      smp_code <= ~cv;
      lcode[ch] = cv;
      lovf[ch] = ov;
      lunf[ch] = un;
      fq.push_back({1'b1, 14'h0, ch, subst(ch, 1'b1)});
      seen[ch] = 1'b1;
      @(posedge sys_clk);
   endtask

   task automatic test_end(input string s);
      $display("test %s done", s);
   endtask

   always @(posedge sys_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1)
         chk("read", {rresp, rdata}, rq.size() ? rq.pop_front() : 34'hx);
      if (bvalid === 1'b1 && bready === 1'b1)
         chk("bresp", {32'h0, bresp}, bq.size() ? {32'h0, bq.pop_front()} : 34'hx);
   end

   initial begin
      repeat (100000) @(posedge sys_clk);
      chk("run timeout", 34'h0, 34'h1);
      tally_and_finish();
   end

   initial begin
      void'($urandom(32'h6876));
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      rd(CTRL_OFF, {RESP_OKAY, 32'h0});
      rd_stat();
      rd_word(1'b0);
      rd(FIFO_OFF + 8'h04, {RESP_SLVERR, 32'h0});
      smp(1'b0, 16'h1234, 1'b0, 1'b0);
      rd_fifo();
      test_end("reset");
      for (int i = 0; i < 12; i++) begin
         c = (i == 0) ? OVS_END : (i == 1) ? UNR_END : 16'(int'($urandom_range(65023)) - 32512);
         wr(CTRL_OFF, {30'h0, i[0], 1'b1}, RESP_OKAY);
         rd_word(i[1]);
         smp(i[1], c, i >= 8 && i < 10, i >= 10);
         rd_word(i[1]);
         rd_fifo();
      end
      test_end("ranges");
      supply <= 1'b0;
      @(posedge sys_clk);
      rd_word(1'b0);
      rd_word(1'b1);
      smp(1'b0, 16'h0100, 1'b0, 1'b0);
      smp(1'b1, 16'h0080, 1'b0, 1'b1);
      rd_fifo();
      rd_fifo();
      rd_stat();
      supply <= 1'b1;
      @(posedge sys_clk);
      rd_word(1'b0);
      test_end("supply");
      wr(CTRL_OFF, 32'hb, RESP_OKAY);
      smp(1'b1, OVS_END, 1'b1, 1'b0);
      rd_word(1'b1);
      rd_fifo();
      smp(1'b0, 16'hfff0, 1'b0, 1'b0);
      rd_word(1'b0);
      wr(STATUS_OFF, 32'hf, RESP_OKAY);
      rd_stat();
      wr(CTRL_OFF, 32'h0, RESP_OKAY);
      rd_word(1'b0);
      rd_word(1'b1);
      test_end("deactivate");
      while (fq.size() != 0) rd_fifo();
      wr(CTRL_OFF, 32'h1, RESP_OKAY);
      for (int i = 0; i < FIFO_DEPTH; i++) smp(i[0], 16'(i * 3), 1'b0, 1'b0);
      smp_valid <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("smp_ready", {33'h0, smp_ready}, 34'h0);
      smp_valid <= 1'b0;
      for (int i = 0; i <= FIFO_DEPTH; i++) rd_fifo();
      rd_stat();
      test_end("fifo");
      tally_and_finish();
   end
endmodule
